// [rtl/dcff_pkg.sv]
/*
  Constants and types shared by the dual-clock FIFO flag logic.
  Assumes a design that samples its pin clocks with one core clock.
*/
package dcff_pkg;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int DCFF_DEPTH = 4096;
	localparam int DCFF_WIDTH = 18;
	localparam int DCFF_OFF_W = 12;

	// ----------------------------------------------------------------
	// Offset register reset values
	// ----------------------------------------------------------------
	localparam logic [11:0] DCFF_EMPTY_OFF_RST = 12'h07F;
	localparam logic [11:0] DCFF_FULL_OFF_RST  = 12'h07F;

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	localparam int          DCFF_FALL_EDGES = 3;
	localparam logic [1:0]  DCFF_FALL_LAST  = 2'(DCFF_FALL_EDGES - 1);

	// ----------------------------------------------------------------
	// Positions of control pins above the data field of the sync vector
	// ----------------------------------------------------------------
	localparam int DCFF_PIN_WCLK = 0;
	localparam int DCFF_PIN_WEN  = 1;
	localparam int DCFF_PIN_RCLK = 2;
	localparam int DCFF_PIN_REN  = 3;
	localparam int DCFF_PIN_LD   = 4;
	localparam int DCFF_PIN_FDS  = 5;
	localparam int DCFF_PIN_RXI  = 6;
	localparam int DCFF_PIN_WXI  = 7;
	localparam int DCFF_PIN_CNT  = 8;

	// ----------------------------------------------------------------
	// Timing modes
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		DCFF_STANDARD = 1'b0,
		DCFF_FIRST_WORD_FALLTHROUGH_MODE     = 1'b1
	} dcff_mode_type;

endpackage

// [rtl/dcff_flag_logic.sv]
/*
  Flag, offset and timing-mode logic of a dual-clock FIFO with its array.
  Assumes write and read clocks arrive as pins sampled by core_clk, each
  far slower than core_clk, so every pin edge is seen in its own cycle.
*/
// Overview of operation
// - Mode pins held steady and sampled during reset.
// - Standard mode: first word waits for a read.
// - Fall-through: first word appears after three read edges.
// - Write enable low stores data on write edges.
// - Fall-through output ready low while word shown.
// - Fall-through almost-empty high at offset plus two.
// - Fall-through half-full low from 2050 words.
// - Fall-through almost-full low from 4097 minus offset.
// - Fall-through input ready high at 4097 words.
// - Reads from full release input ready, then flags.
// - Fall-through almost-empty low at offset plus one.
// - Standard empty flag high once data stored.
// - Standard almost-empty high at offset plus one.
// - Standard half-full low from 2049 words.
// - Standard almost-full low from 4096 minus offset.
// - Standard full flag low at 4096, blocks writes.
// - Standard almost-empty low at offset or fewer.
// - Load writes empty, full offsets in turn.
// - Offset sequence position kept across load releases.
// - Offset readback presents empty then full offset.
// - Offset readback only in standard mode.
// - Pulse chain output on last-location read.
// - Mode pin codes 001 and 101 select fall-through.
// - Half-full released at 2048 words or fewer, 2049 in fall-through.
// - Load low, enable high: write edge ignored.
`timescale 1ns/10ps

module dcff_flag_logic
	import dcff_pkg::*;
#(
	parameter int DEPTH = DCFF_DEPTH,
	parameter int WIDTH = DCFF_WIDTH,
	parameter int OFF_W = DCFF_OFF_W
)(
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             write_clock,
	input  wire logic             write_enable_n,
	input  wire logic [WIDTH-1:0] data_in_bus,
	input  wire logic             read_clock,
	input  wire logic             read_enable_n,
	input  wire logic             offset_load_select,
	input  wire logic             first_device_select,
	input  wire logic             read_chain_in,
	input  wire logic             write_chain_in,
	output logic      [WIDTH-1:0] data_out_bus,
	output logic                  full_flag,
	output logic                  input_ready_flag,
	output logic                  empty_flag,
	output logic                  output_ready_flag,
	output logic                  half_full_flag,
	output logic                  almost_full_flag,
	output logic                  almost_empty_flag,
	output logic                  read_chain_out
);

	// ----------------------------------------------------------------
	// Sizes and elaboration check
	// ----------------------------------------------------------------
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 2;
	localparam int SW = WIDTH + DCFF_PIN_CNT;

	generate
		if (DEPTH != (1 << AW) || OFF_W > AW || OFF_W > WIDTH || DEPTH < 4) begin : g_bad
			$error("dcff_flag_logic: unsupported DEPTH, WIDTH or OFF_W");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Data and enables ride the same two stages as the clocks, so the
	// values seen at a detected edge were stable around that edge.
	logic [SW-1:0] pin_raw;
	logic [SW-1:0] sync_a_reg;
	logic [SW-1:0] sync_b_reg;
	logic          wclk_d_reg;
	logic          rclk_d_reg;

	assign pin_raw = {write_chain_in, read_chain_in, first_device_select,
		offset_load_select, read_enable_n, read_clock, write_enable_n,
		write_clock, data_in_bus};

	always_ff @(posedge core_clk) begin
		sync_a_reg <= pin_raw;
		sync_b_reg <= sync_a_reg;
		wclk_d_reg <= sync_b_reg[WIDTH+DCFF_PIN_WCLK];
		rclk_d_reg <= sync_b_reg[WIDTH+DCFF_PIN_RCLK];
	end

	wire             s_wclk = sync_b_reg[WIDTH+DCFF_PIN_WCLK];
	wire             s_wen_n = sync_b_reg[WIDTH+DCFF_PIN_WEN];
	wire             s_rclk = sync_b_reg[WIDTH+DCFF_PIN_RCLK];
	wire             s_ren_n = sync_b_reg[WIDTH+DCFF_PIN_REN];
	wire             s_ld_n = sync_b_reg[WIDTH+DCFF_PIN_LD];
	wire             s_fds = sync_b_reg[WIDTH+DCFF_PIN_FDS];
	wire             s_rxi = sync_b_reg[WIDTH+DCFF_PIN_RXI];
	wire             s_wxi = sync_b_reg[WIDTH+DCFF_PIN_WXI];
	wire [WIDTH-1:0] s_data = sync_b_reg[WIDTH-1:0];

	wire wr_edge = s_wclk & ~wclk_d_reg;
	wire rd_edge = s_rclk & ~rclk_d_reg;

	// ----------------------------------------------------------------
	// Mode capture
	// ----------------------------------------------------------------
	dcff_mode_type mode_reg;
	logic          fds_cfg_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_reg    <= (~s_rxi & s_wxi) ? DCFF_FIRST_WORD_FALLTHROUGH_MODE : DCFF_STANDARD;
			fds_cfg_reg <= s_fds;
		end
	end

	wire is_first_word_fallthrough_mode = (mode_reg == DCFF_FIRST_WORD_FALLTHROUGH_MODE);
	wire is_std  = (mode_reg == DCFF_STANDARD);

	// ----------------------------------------------------------------
	// Pointers and fill levels
	// ----------------------------------------------------------------
	// Both pin clocks are sampled into core_clk, so the pointers live in
	// one domain and their difference never sees a half-updated value.
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             out_valid_reg;
	logic [1:0]       fall_cnt_reg;
	logic [WIDTH-1:0] mem [DEPTH];

	wire [AW:0]   mem_level = wr_ptr_reg - rd_ptr_reg;
	wire          mem_empty = (mem_level == '0);
	wire          mem_full  = mem_level[AW];
	wire [CW-1:0] total     = {1'b0, mem_level} + CW'(out_valid_reg);
	wire [CW-1:0] fill      = is_first_word_fallthrough_mode ? total : {1'b0, mem_level};
	wire [CW-1:0] extra     = is_first_word_fallthrough_mode ? CW'(1) : CW'(0);

	// ----------------------------------------------------------------
	// Transfer decode
	// ----------------------------------------------------------------
	wire wr_en    = wr_edge & ~s_wen_n;
	wire off_load = wr_en & ~s_ld_n;
	wire fifo_wr  = wr_en & s_ld_n & ~mem_full;
	wire rd_en    = rd_edge & ~s_ren_n;
	wire off_read = rd_en & ~s_ld_n & is_std;
	wire std_rd   = rd_en & s_ld_n & is_std & ~mem_empty;
	wire first_word_fallthrough_mode_rd  = rd_en & s_ld_n & is_first_word_fallthrough_mode & out_valid_reg;
	wire fall_load = is_first_word_fallthrough_mode & ~out_valid_reg & ~mem_empty & rd_edge &
		(fall_cnt_reg == DCFF_FALL_LAST);
	wire mem_pop  = std_rd | (first_word_fallthrough_mode_rd & ~mem_empty) | fall_load;
	wire last_loc = (rd_ptr_reg[AW-1:0] == AW'(DEPTH - 1));

	// ----------------------------------------------------------------
	// Array and pointer update
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (fifo_wr) begin
			mem[wr_ptr_reg[AW-1:0]] <= s_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (fifo_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (mem_pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fall-through output stage
	// ----------------------------------------------------------------
	// The three-edge wait applies only to a word entering an empty output
	// stage; later words follow each read at once.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fall_cnt_reg  <= '0;
			out_valid_reg <= 1'b0;
		end else begin
			if (out_valid_reg | mem_empty | ~is_first_word_fallthrough_mode) begin
				fall_cnt_reg <= '0;
			end else if (rd_edge) begin
				fall_cnt_reg <= fall_cnt_reg + 1'b1;
			end
			if (fall_load | (first_word_fallthrough_mode_rd & ~mem_empty)) begin
				out_valid_reg <= 1'b1;
			end else if (first_word_fallthrough_mode_rd) begin
				out_valid_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Offset registers
	// ----------------------------------------------------------------
	logic [OFF_W-1:0] empty_off_reg;
	logic [OFF_W-1:0] full_off_reg;
	logic             off_wr_sel_reg;
	logic             off_rd_sel_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			empty_off_reg  <= OFF_W'(DCFF_EMPTY_OFF_RST);
			full_off_reg   <= OFF_W'(DCFF_FULL_OFF_RST);
			off_wr_sel_reg <= 1'b0;
			off_rd_sel_reg <= 1'b0;
		end else begin
			if (off_load) begin
				off_wr_sel_reg <= ~off_wr_sel_reg;
				if (off_wr_sel_reg) begin
					full_off_reg <= s_data[OFF_W-1:0];
				end else begin
					empty_off_reg <= s_data[OFF_W-1:0];
				end
			end
			if (off_read) begin
				off_rd_sel_reg <= ~off_rd_sel_reg;
			end
		end
	end

	wire [OFF_W-1:0] off_sel = off_rd_sel_reg ? full_off_reg : empty_off_reg;

	// ----------------------------------------------------------------
	// Flag thresholds
	// ----------------------------------------------------------------
	// One comparator per flag serves both modes; fall-through adds one
	// word to every threshold because the output stage holds a word.
	wire [CW-1:0] ae_thr = CW'(empty_off_reg) + CW'(1) + extra;
	wire [CW-1:0] hf_thr = CW'(DEPTH / 2) + CW'(1) + extra;
	wire [CW-1:0] af_thr = CW'(DEPTH) + extra - CW'(full_off_reg);

	wire ae_high = (fill >= ae_thr);
	wire hf_low  = (fill >= hf_thr);
	wire af_low  = (fill >= af_thr);
	wire fw_full = (total == CW'(DEPTH + 1));

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			data_out_bus      <= '0;
			full_flag         <= 1'b1;
			input_ready_flag  <= 1'b0;
			output_ready_flag <= 1'b1;
			half_full_flag    <= 1'b1;
			almost_full_flag  <= 1'b1;
			almost_empty_flag <= 1'b0;
			read_chain_out    <= 1'b0;
		end else begin
			if (off_read) begin
				data_out_bus <= {{(WIDTH-OFF_W){1'b0}}, off_sel};
			end else if (mem_pop) begin
				data_out_bus <= mem[rd_ptr_reg[AW-1:0]];
			end
			full_flag         <= ~(is_std & mem_full);
			input_ready_flag  <= is_first_word_fallthrough_mode & fw_full;
			output_ready_flag <= ~(is_first_word_fallthrough_mode & out_valid_reg);
			half_full_flag    <= ~hf_low;
			almost_full_flag  <= ~af_low;
			almost_empty_flag <= ae_high;
			read_chain_out    <= mem_pop & last_loc;
		end
	end

	// The empty pin tracks the mode even in reset, so fall-through mode
	// never shows a false empty on the first cycle after release.
	always_ff @(posedge core_clk) begin
		empty_flag <= ~is_std | ~mem_empty;
	end

endmodule

// [verification/dcff_flag_asserts.sv]
/* Port checker for the dual-clock FIFO flag logic.
   Assumes a bind onto dcff_flag_logic with straps held during reset. */
`timescale 1ns/10ps
module dcff_flag_asserts
	import dcff_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        read_clock,
	input wire logic        read_chain_in,
	input wire logic        write_chain_in,
	input wire logic [17:0] data_out_bus,
	input wire logic        full_flag,
	input wire logic        input_ready_flag,
	input wire logic        empty_flag,
	input wire logic        output_ready_flag,
	input wire logic        half_full_flag,
	input wire logic        almost_full_flag,
	input wire logic        almost_empty_flag,
	input wire logic        read_chain_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic       first_word_fallthrough_mode_reg;
	logic       rc_reg;
	logic [3:0] since_reg;
	// The age of the last read clock rise saturates so it never wraps into a false pass.
	always_ff @(posedge core_clk) begin
		rc_reg <= read_clock;
		if (rst) begin
			first_word_fallthrough_mode_reg <= !read_chain_in && write_chain_in;
			since_reg <= 4'hF;
		end else if (read_clock && !rc_reg) begin
			since_reg <= 4'h0;
		end else if (since_reg != 4'hF) begin
			since_reg <= since_reg + 4'h1;
		end
	end
	a_std_idle_pins: assert property (!first_word_fallthrough_mode_reg |-> !input_ready_flag && output_ready_flag)
		else $error("standard mode drives fall-through pins");
	a_first_word_fallthrough_mode_idle_pins: assert property (first_word_fallthrough_mode_reg |-> full_flag && empty_flag)
		else $error("fall-through mode drives standard pins");
	a_full_flag_set: assert property (!full_flag |-> !almost_full_flag && !half_full_flag)
		else $error("full without almost full and half full");
	a_std_ae_fill: assert property (!first_word_fallthrough_mode_reg && almost_empty_flag |-> empty_flag)
		else $error("almost empty released on empty memory");
	a_af_needs_hf: assert property (!almost_full_flag |-> !half_full_flag)
		else $error("almost full without half full");
	a_empty_ae_low: assert property (!first_word_fallthrough_mode_reg && !empty_flag |-> !almost_empty_flag)
		else $error("almost empty high while empty");
	a_or_ae_low: assert property (first_word_fallthrough_mode_reg && output_ready_flag |-> !almost_empty_flag)
		else $error("almost empty high with no word shown");
	a_chain_one_pulse: assert property ($rose(read_chain_out) |=> !read_chain_out)
		else $error("chain pulse longer than one cycle");
	a_data_needs_read: assert property (!first_word_fallthrough_mode_reg && $changed(data_out_bus) |-> since_reg < 4'h8)
		else $error("output data changed without a read edge");
endmodule

// [verification/dcff_link_model.sv]
/* Writer and reader port clocks of the far side.
   Assumes the clocks run free, as the ports allow, at 400 ns each. */
`timescale 1ns/10ps
module dcff_link_model (
	output logic write_clock,
	output logic read_clock
);
	// Odd offsets keep every pin edge away from the core clock edges.
	initial begin
		write_clock = 1'b0;
		#10;
		forever #200 write_clock = ~write_clock;
	end
	initial begin
		read_clock = 1'b0;
		#170;
		forever #200 read_clock = ~read_clock;
	end
endmodule

// [verification/dcff_flag_logic_tb.sv]
/* Self-checking bench for dcff_flag_logic.
   Assumes dcff_link_model makes both pin clocks. */
`timescale 1ns/10ps
module dcff_flag_logic_tb;
	import dcff_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        write_enable_n = 1'b1;
	logic        read_enable_n = 1'b1;
	logic        offset_load_select = 1'b1;
	logic        first_device_select = 1'b0;
	logic        read_chain_in = 1'b0;
	logic        write_chain_in = 1'b0;
	logic        chk = 1'b0;
	logic        first_word_fallthrough_mode = 1'b0;
	logic [17:0] data_in_bus = 18'h00000;
	logic [17:0] data_out_bus;
	logic [17:0] last;
	logic [31:0] seed = 32'h00000038;
	logic [2:0]  codes [6] = '{3'h0, 3'h3, 3'h4, 3'h7, 3'h1, 3'h5};
	logic [17:0] exp_q [$];
	logic [17:0] model_q [$];
	logic        full_flag, input_ready_flag, empty_flag, output_ready_flag;
	logic        half_full_flag, almost_full_flag, almost_empty_flag, read_chain_out;
	wire         write_clock;
	wire         read_clock;
	int          err_count = 0;
	int          tests_run = 0;
	int          pulses = 0;
	int          cnt;
	int          n;
	int          m;
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	dcff_link_model link_u (.*);
	dcff_flag_logic dut_u (.*);
	function automatic logic [17:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[17:0];
	endfunction
	function automatic logic [6:0] exp_flags();
		int f;
		f = first_word_fallthrough_mode ? 4097 : 4096;
		return {first_word_fallthrough_mode || cnt < 4096, first_word_fallthrough_mode && cnt >= 4097, first_word_fallthrough_mode || cnt != 0, !first_word_fallthrough_mode || cnt == 0,
			cnt < f - 2047, cnt < f - m, cnt >= n + 1 + first_word_fallthrough_mode};
	endfunction
	function automatic bit near();
		return cnt < 8 || cnt % 512 == 0 || cnt > 4080 || (cnt > 2046 && cnt < 2051);
	endfunction
	task automatic finish_test();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic cmp_d(input logic [17:0] e, input logic [17:0] a);
		tests_run++;
		if (a !== e) begin
			err_count++;
			$display("ERROR %0t exp %h got %h", $time, e, a);
		end
	endtask
	task automatic cmp_f(input logic [6:0] e, input logic [6:0] a);
		tests_run++;
		if (a !== e) begin
			err_count++;
			$display("ERROR %0t exp %h got %h", $time, e, a);
		end
	endtask
	task automatic wait_clk(input bit r, input logic v);
		int i;
		for (i = 0; i < 40 && (r ? read_clock : write_clock) !== v; i++) begin
			@(posedge core_clk);
		end
		if (i == 40) begin
			err_count++;
			finish_test();
		end
	endtask
	task automatic note(input logic [17:0] e);
		exp_q.push_back(e);
		chk <= 1'b1;
		@(posedge core_clk);
		chk <= 1'b0;
	endtask
	always @(posedge core_clk) begin
		if (chk) cmp_d(exp_q.pop_front(), data_out_bus);
		if (read_chain_out === 1'b1) pulses++;
	end
	task automatic chk_flags();
		repeat (8) @(posedge core_clk);
		cmp_f(exp_flags(), {full_flag, input_ready_flag, empty_flag, output_ready_flag,
			half_full_flag, almost_full_flag, almost_empty_flag});
	endtask
	// Enables change while the pin clock is low so they meet exactly one rise.
	task automatic xfer(input bit r, input logic ld_n, input logic [17:0] d);
		@(posedge core_clk);
		wait_clk(r, 1'b0);
		if (r) read_enable_n <= 1'b0;
		else write_enable_n <= 1'b0;
		if (!r) data_in_bus <= d;
		offset_load_select <= ld_n;
		wait_clk(r, 1'b1);
		wait_clk(r, 1'b0);
		read_enable_n <= 1'b1;
		write_enable_n <= 1'b1;
		offset_load_select <= 1'b1;
		if (r) note(d);
	endtask
	task automatic put();
		logic [17:0] w;
		w = rnd();
		xfer(1'b0, 1'b1, w);
		if (cnt < 4096 + first_word_fallthrough_mode) begin
			model_q.push_back(w);
			cnt++;
		end
	endtask
	task automatic get();
		if (cnt > 0) begin
			last = (first_word_fallthrough_mode && cnt > 1) ? model_q[1] : model_q[0];
			void'(model_q.pop_front());
			cnt--;
		end
		xfer(1'b1, 1'b1, last);
	endtask
	task automatic do_rst(input logic [2:0] s);
		@(posedge core_clk);
		{first_device_select, read_chain_in, write_chain_in} <= s;
		rst <= 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		first_word_fallthrough_mode = s[1:0] == 2'b01;
		cnt = 0;
		n = 127;
		m = 127;
		last = 18'h00000;
		model_q.delete();
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		foreach (codes[i]) begin
			do_rst(codes[i]);
			chk_flags();
		end
		$display("mode test done");
		do_rst(3'h0);
		put();
		chk_flags();
		note(18'h00000);
		get();
		chk_flags();
		get();
		$display("first word test done");
		offset_load_select <= 1'b0;
		wait_clk(1'b0, 1'b0);
		wait_clk(1'b0, 1'b1);
		wait_clk(1'b0, 1'b0);
		xfer(1'b0, 1'b0, 18'h3F005);
		xfer(1'b0, 1'b0, 18'h3F00A);
		xfer(1'b1, 1'b0, 18'h00005);
		xfer(1'b1, 1'b0, 18'h0000A);
		n = 5;
		m = 10;
		for (int i = 0; i < 4097; i++) begin
			put();
			if (near()) chk_flags();
		end
		for (int i = 0; i < 4097; i++) begin
			get();
			if (near()) chk_flags();
		end
		cmp_f(7'h01, 7'(pulses));
		$display("fill test done");
		do_rst(3'h1);
		xfer(1'b0, 1'b0, 18'h00003);
		n = 3;
		put();
		repeat (48) @(posedge core_clk);
		note(model_q[0]);
		chk_flags();
		repeat (5) begin
			put();
			chk_flags();
		end
		xfer(1'b1, 1'b0, model_q[0]);
		repeat (7) begin
			get();
			chk_flags();
		end
		$display("fall-through test done");
		finish_test();
	end
endmodule
bind dcff_flag_logic dcff_flag_asserts chk_u (.*);
